// *** hdl/aesacc_pkg.sv ***
package aesacc_pkg;

  // slave address width and register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DATA0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_KEY0 = 8'h20;

  // field positions
  localparam int CTRL_DEC_BIT = 0;
  localparam int CTRL_K256_BIT = 1;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CLR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // bus transfer size code for a full word
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // cycle counts and round counts per key length
  localparam logic [6:0] LAT_K128 = 7'h34;
  localparam logic [6:0] LAT_K256 = 7'h4B;
  localparam logic [6:0] NR_K128 = 7'h0A;
  localparam logic [6:0] NR_K256 = 7'h0E;
  localparam logic [6:0] FIRST_STEP_K128 = 7'h01;
  localparam logic [6:0] FIRST_STEP_K256 = 7'h02;
  localparam int NUM_RKEYS = 15;

  // values after reset and at start
  localparam logic [7:0] RCON_INIT = 8'h01;
  localparam logic [6:0] CNT_RST = 7'h00;

  // operation state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } aesacc_state_t;

  // multiply by x in the cipher field
  function automatic logic [7:0] gf_xtime(input logic [7:0] a);
    gf_xtime = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  // general field multiply
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        r = r ^ p;
      end
      p = gf_xtime(p);
    end
    gf_mul = r;
  endfunction

  // field inverse as a to the power 254, zero maps to zero
  function automatic logic [7:0] gf_inv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gf_mul(p, p);
      r = gf_mul(r, p);
    end
    gf_inv = r;
  endfunction

  function automatic logic [7:0] rotl8(input logic [7:0] a, input int n);
    rotl8 = 8'((a << n) | (a >> (8 - n)));
  endfunction

  // forward substitution: inverse then affine map
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] v;
    v = gf_inv(a);
    sbox = v ^ rotl8(v, 1) ^ rotl8(v, 2) ^ rotl8(v, 3) ^ rotl8(v, 4) ^ 8'h63;
  endfunction

  // inverse substitution: inverse affine map then inverse
  function automatic logic [7:0] inv_sbox(input logic [7:0] a);
    inv_sbox = gf_inv(rotl8(a, 1) ^ rotl8(a, 3) ^ rotl8(a, 6) ^ 8'h05);
  endfunction

  // column mix, forward or inverse coefficients
  function automatic logic [31:0] mix_col(input logic [31:0] w, input logic inv);
    logic [7:0] cf [4];
    logic [7:0] acc;
    logic [31:0] res;
    cf[0] = inv ? 8'h0E : 8'h02;
    cf[1] = inv ? 8'h0B : 8'h03;
    cf[2] = inv ? 8'h0D : 8'h01;
    cf[3] = inv ? 8'h09 : 8'h01;
    res = 32'h0000_0000;
    for (int r = 0; r < 4; r++) begin
      acc = 8'h00;
      for (int j = 0; j < 4; j++) begin
        acc = acc ^ gf_mul(cf[(j - r + 4) % 4], w[31 - 8 * j -: 8]);
      end
      res[31 - 8 * r -: 8] = acc;
    end
    mix_col = res;
  endfunction

  // substitute each byte of a word
  function automatic logic [31:0] sub_word(input logic [31:0] w);
    sub_word = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

endpackage

// *** hdl/aesacc_round.sv ***
`timescale 1ns/1ps
module aesacc_round (
  // round input
  input wire logic [127:0] state_i,
  input wire logic [127:0] rkey_i,
  input wire logic decrypt_i,
  input wire logic last_i,
  // round output
  output logic [127:0] state_o
);
  import aesacc_pkg::*;

  logic [127:0] sub_w;
  logic [127:0] enc_mix;
  logic [127:0] dec_key;
  logic [127:0] dec_mix;

  // row shift and byte substitution, byte b sits at row b%4, column b/4
  genvar gb;
  generate
    for (gb = 0; gb < 16; gb++) begin : g_byte
      localparam int ROW = gb % 4;
      localparam int COL = gb / 4;
      localparam int ESRC = 4 * ((COL + ROW) % 4) + ROW;
      localparam int DSRC = 4 * ((COL + 4 - ROW) % 4) + ROW;
      assign sub_w[127 - 8 * gb -: 8] = decrypt_i ? inv_sbox(state_i[127 - 8 * DSRC -: 8])
                                                  : sbox(state_i[127 - 8 * ESRC -: 8]);
    end
  endgenerate

  // column mixing, forward on the substituted state, inverse after key add
  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_col
      assign enc_mix[127 - 32 * gc -: 32] = mix_col(sub_w[127 - 32 * gc -: 32], 1'b0);
      assign dec_mix[127 - 32 * gc -: 32] = mix_col(dec_key[127 - 32 * gc -: 32], 1'b1);
    end
  endgenerate

  assign dec_key = sub_w ^ rkey_i;

  // final round skips column mixing in both directions
  always_comb begin
    if (decrypt_i) begin
      state_o = last_i ? dec_key : dec_mix;
    end else begin
      state_o = (last_i ? sub_w : enc_mix) ^ rkey_i;
    end
  end

endmodule

// *** hdl/aesacc_top.sv ***
`timescale 1ns/1ps
module aesacc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // ahb-lite slave, address phase
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  // ahb-lite slave, data phase
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  import aesacc_pkg::*;

  logic [ADDR_W-1:0] addr_ff;
  logic wr_ff;
  logic word_ff;
  aesacc_state_t state_ff;
  logic [6:0] cnt_ff;
  logic ctrl_dec_ff;
  logic ctrl_k256_ff;
  logic run_dec_ff;
  logic run_k256_ff;
  logic done_ff;
  logic [127:0] data_ff;
  logic [255:0] key_ff;
  logic [127:0] rk_ff [NUM_RKEYS];
  logic [7:0] rcon_ff;

  logic bus_wr;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_data;
  logic wr_key;
  logic idle;
  logic busy;
  logic start;
  logic clr_done;
  logic finish;
  logic [6:0] nr;
  logic [6:0] lat;
  logic [6:0] first_step;
  logic exp_step;
  logic init_step;
  logic round_step;
  logic [3:0] step;
  logic [3:0] round_num;
  logic [3:0] rk_sel;
  logic use_rot;
  logic [127:0] prev_rk;
  logic [127:0] prev2_rk;
  logic [31:0] tmp_w;
  logic [127:0] nxt_rk;
  logic [127:0] rnd_out;

  // address phase capture; the slave never stalls and never errors
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      addr_ff <= OFF_CTRL;
      wr_ff <= 1'b0;
      word_ff <= 1'b0;
    end else if (hready_i) begin
      addr_ff <= haddr_i[ADDR_W-1:0];
      wr_ff <= hsel_i & htrans_i[1] & hwrite_i;
      word_ff <= (hsize_i == HSIZE_WORD);
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // write decode; narrow writes are dropped, only full-word writes take effect
  assign bus_wr = wr_ff & word_ff;
  assign wr_ctrl = bus_wr & (addr_ff == OFF_CTRL);
  assign wr_cmd = bus_wr & (addr_ff == OFF_CMD);
  assign wr_data = bus_wr & (addr_ff[7:4] == OFF_DATA0[7:4]);
  assign wr_key = bus_wr & (addr_ff[7:5] == OFF_KEY0[7:5]);

  assign idle = (state_ff == ST_IDLE);
  assign busy = (state_ff == ST_RUN);
  assign start = wr_cmd & hwdata_i[CMD_START_BIT] & idle;
  assign clr_done = wr_cmd & hwdata_i[CMD_CLR_BIT];

  // per-key-length schedule figures
  assign nr = run_k256_ff ? NR_K256 : NR_K128;
  assign lat = run_k256_ff ? LAT_K256 : LAT_K128;
  assign first_step = run_k256_ff ? FIRST_STEP_K256 : FIRST_STEP_K128;
  assign finish = busy & (cnt_ff == lat - 7'h01);

  // phases: key expansion, initial key add, then one round per cycle
  assign exp_step = busy & (cnt_ff >= first_step) & (cnt_ff <= nr);
  assign init_step = busy & (cnt_ff == nr + 7'h01);
  assign round_step = busy & (cnt_ff > nr + 7'h01) & (cnt_ff <= {nr[5:0], 1'b1});
  assign step = cnt_ff[3:0];
  assign round_num = 4'(cnt_ff - nr - 7'h01);

  // round key pick: decryption walks the schedule backwards
  always_comb begin
    if (init_step) begin
      rk_sel = run_dec_ff ? nr[3:0] : 4'h0;
    end else begin
      rk_sel = run_dec_ff ? 4'(nr[3:0] - round_num) : round_num;
    end
  end

  // key expansion, four words per cycle
  assign use_rot = ~run_k256_ff | ~step[0];
  assign prev_rk = rk_ff[4'(step - 4'h1)];
  assign prev2_rk = run_k256_ff ? rk_ff[4'(step - 4'h2)] : prev_rk;

  always_comb begin
    tmp_w = prev_rk[31:0];
    if (use_rot) begin
      tmp_w = sub_word({prev_rk[23:0], prev_rk[31:24]}) ^ {rcon_ff, 24'h000000};
    end else begin
      tmp_w = sub_word(prev_rk[31:0]);
    end
    nxt_rk[127:96] = prev2_rk[127:96] ^ tmp_w;
    nxt_rk[95:64] = prev2_rk[95:64] ^ nxt_rk[127:96];
    nxt_rk[63:32] = prev2_rk[63:32] ^ nxt_rk[95:64];
    nxt_rk[31:0] = prev2_rk[31:0] ^ nxt_rk[63:32];
  end

  // round key store
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_RKEYS; i++) begin
        rk_ff[i] <= 128'h0;
      end
    end else if (start) begin
      rk_ff[0] <= key_ff[255:128];
      rk_ff[1] <= key_ff[127:0];
    end else if (exp_step) begin
      rk_ff[step] <= nxt_rk;
    end
  end

  // round constant walks by doubling on each rotating step
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rcon_ff <= RCON_INIT;
    end else if (start) begin
      rcon_ff <= RCON_INIT;
    end else if (exp_step & use_rot) begin
      rcon_ff <= gf_xtime(rcon_ff);
    end
  end

  aesacc_round u_round (
    .state_i(data_ff),
    .rkey_i(rk_ff[rk_sel]),
    .decrypt_i(run_dec_ff),
    .last_i(round_num == nr[3:0]),
    .state_o(rnd_out)
  );

  // data block: loaded by the bus while idle, transformed in place while busy
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_ff <= 128'h0;
    end else if (round_step) begin
      data_ff <= rnd_out;
    end else if (init_step) begin
      data_ff <= data_ff ^ rk_ff[rk_sel];
    end else if (wr_data & idle) begin
      for (int i = 0; i < 4; i++) begin
        if (addr_ff[3:2] == 2'(i)) begin
          data_ff[127 - 32 * i -: 32] <= hwdata_i;
        end
      end
    end
  end

  // key words, written only while idle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      key_ff <= 256'h0;
    end else if (wr_key & idle) begin
      for (int i = 0; i < 8; i++) begin
        if (addr_ff[4:2] == 3'(i)) begin
          key_ff[255 - 32 * i -: 32] <= hwdata_i;
        end
      end
    end
  end

  // direction and key length settings
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_dec_ff <= 1'b0;
      ctrl_k256_ff <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_dec_ff <= hwdata_i[CTRL_DEC_BIT];
      ctrl_k256_ff <= hwdata_i[CTRL_K256_BIT];
    end
  end

  // operation sequencer; settings are frozen at start
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_RST;
      run_dec_ff <= 1'b0;
      run_k256_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_RUN;
            cnt_ff <= CNT_RST;
            run_dec_ff <= ctrl_dec_ff;
            run_k256_ff <= ctrl_k256_ff;
          end
        end
        ST_RUN: begin
          cnt_ff <= cnt_ff + 7'h01;
          if (finish) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // completion flag, completion wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (start | clr_done) begin
      done_ff <= 1'b0;
    end
  end

  // read mux from the captured address; unmapped offsets read zero
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (addr_ff == OFF_CTRL) begin
      hrdata_o[CTRL_DEC_BIT] = ctrl_dec_ff;
      hrdata_o[CTRL_K256_BIT] = ctrl_k256_ff;
    end else if (addr_ff == OFF_STATUS) begin
      hrdata_o[STAT_BUSY_BIT] = busy;
      hrdata_o[STAT_DONE_BIT] = done_ff;
    end else if (addr_ff[7:4] == OFF_DATA0[7:4]) begin
      hrdata_o = data_ff[127 - 32 * addr_ff[3:2] -: 32];
    end else if (addr_ff[7:5] == OFF_KEY0[7:5]) begin
      hrdata_o = key_ff[255 - 32 * addr_ff[4:2] -: 32];
    end
  end

endmodule

// *** tb/aesacc_ahb_model.sv ***
`timescale 1ns/1ps
module aesacc_ahb_model (
  // bus clock
  input wire logic clk_i,
  // address phase
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  // data phase
  output logic [31:0] hwdata_o,
  input wire logic [31:0] hrdata_i
);
  import aesacc_pkg::*;
  // idle bus from time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = HSIZE_WORD;
    hwdata_o = 32'h0;
  end
  // address phase after a falling edge, taken at the next rising edge
  task automatic addr_phase(input logic [7:0] a, input logic w, input logic [2:0] s);
    @(negedge clk_i);
    hwdata_o = ~hwdata_o;
    hsel_o = 1'b1;
    haddr_o = {24'h0, a};
    htrans_o = 2'h2;
    hwrite_o = w;
    hsize_o = s;
    @(posedge clk_i);
  endtask
  // release the address lines, leaving a changed pattern behind
  task automatic release_addr();
    @(negedge clk_i);
    hsel_o = 1'b0;
    htrans_o = 2'h0;
    haddr_o = ~haddr_o;
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [2:0] s);
    addr_phase(a, 1'b1, s);
    release_addr();
    hwdata_o = d;
    @(posedge clk_i);
  endtask
  // read data is taken at the edge that closes the data phase, before it moves on
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    addr_phase(a, 1'b0, HSIZE_WORD);
    release_addr();
    @(posedge clk_i);
    d = hrdata_i;
  endtask
endmodule

// *** tb/aesacc_sva.sv ***
`timescale 1ns/1ps
module aesacc_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bus inputs
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  // bus outputs
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o
);
  import aesacc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic dp_ff;
  logic wr_ff;
  logic word_ff;
  logic [7:0] ad_ff;
  logic [1:0] ctrl_ff;
  logic [6:0] cnt_ff;
  logic done_ff;
  logic wr_cmd;
  logic go;
  logic rd_stat;
  // decoded data-phase events
  assign wr_cmd = dp_ff && wr_ff && word_ff && ad_ff == OFF_CMD;
  assign go = wr_cmd && hwdata_i[CMD_START_BIT] && cnt_ff == CNT_RST;
  assign rd_stat = dp_ff && !wr_ff && ad_ff == OFF_STATUS;
  // address phase capture
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) dp_ff <= 1'b0;
    else if (hready_i) dp_ff <= hsel_i & htrans_i[1];
  end
  always_ff @(posedge clk_i) begin
    if (hready_i) begin
      ad_ff <= haddr_i[7:0];
      wr_ff <= hwrite_i;
      word_ff <= hsize_i == HSIZE_WORD;
    end
  end
  // control bits as software last wrote them
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) ctrl_ff <= 2'h0;
    else if (dp_ff && wr_ff && word_ff && ad_ff == OFF_CTRL) ctrl_ff <= hwdata_i[1:0];
  end
  // cycles left of the running block
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) cnt_ff <= CNT_RST;
    else if (go) cnt_ff <= ctrl_ff[CTRL_K256_BIT] ? LAT_K256 : LAT_K128;
    else if (cnt_ff != CNT_RST) cnt_ff <= cnt_ff - 7'h01;
  end
  // completion flag, setting wins over clearing
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) done_ff <= 1'b0;
    else if (cnt_ff == 7'h01) done_ff <= 1'b1;
    else if (go || (wr_cmd && hwdata_i[CMD_CLR_BIT])) done_ff <= 1'b0;
  end
  busy_window_a: assert property (rd_stat |-> hrdata_o[STAT_BUSY_BIT] == (cnt_ff != CNT_RST))
    else $error("busy bit outside the latency window");
  done_flag_a: assert property (rd_stat |-> hrdata_o[STAT_DONE_BIT] == done_ff)
    else $error("completion flag wrong");
  zero_wait_a: assert property (hsel_i && htrans_i[1] |=> hreadyout_o && !hresp_o)
    else $error("data phase not zero wait okay");
  okay_resp_a: assert property (!hresp_o)
    else $error("error response seen");
  ctrl_readback_a: assert property (dp_ff && !wr_ff && ad_ff == OFF_CTRL |-> hrdata_o[1:0] == ctrl_ff)
    else $error("mode bits read back wrong");
  cmd_reads_zero_a: assert property (dp_ff && !wr_ff && ad_ff == OFF_CMD |-> hrdata_o == 32'h0)
    else $error("command register not reading zero");
endmodule

bind aesacc_top aesacc_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

// *** tb/test_aes_block_cipher_accelerator.sv ***
`timescale 1ns/1ps
module test_aes_block_cipher_accelerator;
  import aesacc_pkg::*;
  localparam logic [255:0] KEY = {128'h000102030405060708090A0B0C0D0E0F,
                                  128'h101112131415161718191A1B1C1D1E1F};
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] C1 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] C2 = 128'h8EA2B7CA516745BFEAFC49904B496089;
  typedef struct packed {logic k256; logic dec; logic [127:0] din; logic [127:0] dout;} aesacc_row_t;
  aesacc_row_t rows [4] = '{'{1'b0, 1'b0, PT, C1}, '{1'b0, 1'b1, C1, PT},
                            '{1'b1, 1'b0, PT, C2}, '{1'b1, 1'b1, C2, PT}};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel_i;
  logic [31:0] haddr_i;
  logic [1:0] htrans_i;
  logic hwrite_i;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [31:0] rd;
  int fail_count = 0;
  int check_count = 0;
  always #50 clk_i = ~clk_i;
  aesacc_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
  aesacc_ahb_model m (.clk_i(clk_i), .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i),
    .hwrite_o(hwrite_i), .hsize_o(hsize_i), .hwdata_o(hwdata_i), .hrdata_i(hrdata_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // start a block, optionally poking it while busy, then probe both sides of the finish edge
  task automatic run_op(input logic k, input logic poke);
    int n;
    n = k ? 75 : 52;
    m.bus_write(OFF_CMD, 32'h1, HSIZE_WORD);
    if (poke) begin
      m.bus_write(OFF_CMD, 32'h1, HSIZE_WORD);
      m.bus_write(OFF_DATA0, 32'hDEADBEEF, HSIZE_WORD);
      n = n - 4;
    end
    repeat (n - 3) @(posedge clk_i);
    m.bus_read(OFF_STATUS, rd);
    check({30'h0, rd[1:0]}, 32'h1);
    m.bus_read(OFF_STATUS, rd);
    check({30'h0, rd[1:0]}, 32'h2);
  endtask
  task automatic check_data(input logic [127:0] exp);
    for (int i = 0; i < 4; i++) begin
      m.bus_read(OFF_DATA0 + 8'(4 * i), rd);
      check(rd, exp[127 - 32 * i -: 32]);
    end
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    // each direction with each key length
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 8; i++) m.bus_write(OFF_KEY0 + 8'(4 * i), KEY[255 - 32 * i -: 32], HSIZE_WORD);
      for (int i = 0; i < 4; i++) m.bus_write(OFF_DATA0 + 8'(4 * i), rows[r].din[127 - 32 * i -: 32], HSIZE_WORD);
      m.bus_write(OFF_CTRL, {30'h0, rows[r].k256, rows[r].dec}, HSIZE_WORD);
      run_op(rows[r].k256, 1'b0);
      check_data(rows[r].dout);
    end
    // flag holds until cleared, key readable, command reads zero
    repeat (5) @(posedge clk_i);
    m.bus_read(OFF_STATUS, rd);
    check({30'h0, rd[1:0]}, 32'h2);
    m.bus_write(OFF_CMD, 32'h2, HSIZE_WORD);
    m.bus_read(OFF_STATUS, rd);
    check({30'h0, rd[1:0]}, 32'h0);
    m.bus_read(OFF_KEY0 + 8'h1C, rd);
    check(rd, KEY[31:0]);
    m.bus_read(OFF_CMD, rd);
    check(rd, 32'h0);
    // narrow write refused, unmapped address reads zero
    m.bus_write(OFF_CTRL, 32'h0, 3'h0);
    m.bus_read(OFF_CTRL, rd);
    check({30'h0, rd[1:0]}, 32'h3);
    m.bus_read(8'hF0, rd);
    check(rd, 32'h0);
    // start and data writes while busy are ignored
    m.bus_write(OFF_CTRL, 32'h0, HSIZE_WORD);
    run_op(1'b0, 1'b1);
    check_data(C1);
    // reset in mid-run, with non-zero settings so that the reset values show
    m.bus_write(OFF_CTRL, 32'h3, HSIZE_WORD);
    m.bus_write(OFF_CMD, 32'h1, HSIZE_WORD);
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    m.bus_read(OFF_STATUS, rd);
    check(rd, 32'h0);
    m.bus_read(OFF_CTRL, rd);
    check(rd, 32'h0);
    check_data(128'h0);
    m.bus_read(OFF_KEY0, rd);
    check(rd, 32'h0);
    tally_and_finish();
  end
endmodule
